// [rtl/pps_pkg.sv]
package pps_pkg;
  localparam int unsigned CLK_HZ = 100_000_000;
  localparam int unsigned FSW_HZ = 65_000;
  localparam int unsigned TICK_HZ = 6_500;
  localparam int unsigned RELAY_SETTLE_US = 20_000;
  localparam int unsigned CNT_W = 11;
  localparam logic [CNT_W-1:0] PERIOD_CYC = CNT_W'(CLK_HZ / FSW_HZ);
  localparam logic [CNT_W-1:0] PERIOD_LAST = CNT_W'(CLK_HZ / FSW_HZ - 1);
  localparam int unsigned TICK_CYC = CLK_HZ / TICK_HZ;
  localparam int unsigned RELAY_SETTLE_CYC = (CLK_HZ / 1_000_000) * RELAY_SETTLE_US;
  localparam int unsigned DATA_W = 16;
  localparam int unsigned COEF_FRAC = 14;
  localparam int unsigned NUM_SECT = 4;
  localparam logic [DATA_W-1:0] BULK_MIN_DEFAULT = 16'h5000;
  localparam logic [CNT_W-1:0] DUTY_RESET = 11'h000;
  typedef enum logic [1:0] {
    PPS_IDLE = 2'b00,
    PPS_RELAY = 2'b01,
    PPS_RUN = 2'b10
  } pps_seq_t;
endpackage : pps_pkg

// [rtl/pps_bq_if.sv]
`timescale 1ns/10ps
// one biquad section: sample in, coefficients in, filtered sample out
interface pps_bq_if;
  import pps_pkg::*;
  logic signed [DATA_W-1:0] x;
  logic x_vld;
  logic signed [4:0][DATA_W-1:0] coef;
  logic signed [DATA_W-1:0] y;
  logic y_vld;
  modport feed (output x, output x_vld, output coef, input y, input y_vld);
  modport sect (input x, input x_vld, input coef, output y, output y_vld);
endinterface : pps_bq_if

// [rtl/pps_biquad.sv]
`timescale 1ns/10ps
// direct form I second-order section; coef order b0 b1 b2 a1 a2, Q2.14
module pps_biquad
  import pps_pkg::*;
(
  input wire logic sys_clk_in,
  input wire logic reset_in,
  pps_bq_if.sect bq
);
  localparam int unsigned ACC_W = 2 * DATA_W + 3;
  logic signed [DATA_W-1:0] x1_q, x1_d, x2_q, x2_d, y1_q, y1_d, y2_q, y2_d, y_q, y_d;
  logic vld_q, vld_d;
  logic signed [ACC_W-1:0] acc;

  // all five products summed in one cycle per update; result truncated, no saturation
  always_comb begin
    // element selects of the packed array are unsigned, so each coefficient is re-signed
    acc = ACC_W'($signed(bq.coef[0]) * bq.x) + ACC_W'($signed(bq.coef[1]) * x1_q)
        + ACC_W'($signed(bq.coef[2]) * x2_q) - ACC_W'($signed(bq.coef[3]) * y1_q)
        - ACC_W'($signed(bq.coef[4]) * y2_q);
    x1_d = x1_q;
    x2_d = x2_q;
    y1_d = y1_q;
    y2_d = y2_q;
    y_d = y_q;
    vld_d = 1'b0;
    if (bq.x_vld) begin
      y_d = acc[COEF_FRAC +: DATA_W];
      x2_d = x1_q;
      x1_d = bq.x;
      y2_d = y1_q;
      y1_d = acc[COEF_FRAC +: DATA_W];
      vld_d = 1'b1;
    end
  end

  always_ff @(posedge sys_clk_in or posedge reset_in) begin
    if (reset_in) begin
      x1_q <= '0;
      x2_q <= '0;
      y1_q <= '0;
      y2_q <= '0;
      y_q <= '0;
      vld_q <= 1'b0;
    end else begin
      x1_q <= x1_d;
      x2_q <= x2_d;
      y1_q <= y1_d;
      y2_q <= y2_d;
      y_q <= y_d;
      vld_q <= vld_d;
    end
  end

  assign bq.y = y_q;
  assign bq.y_vld = vld_q;
endmodule : pps_biquad

// [rtl/pps_pwm_sampling_sequencer.sv]
`timescale 1ns/10ps
module pps_pwm_sampling_sequencer
  import pps_pkg::*;
#(
  parameter int unsigned TICK_CYCLES = TICK_CYC,
  parameter int unsigned RELAY_CYCLES = RELAY_SETTLE_CYC
) (
  input wire logic sys_clk_in,
  input wire logic reset_in,
  input wire logic enable_in,
  input wire logic [CNT_W-1:0] duty_in,
  input wire logic duty_load_in,
  input wire logic cur_conv_done_in,
  input wire logic peak_current_limit_in,
  input wire logic trap_clear_in,
  input wire logic zero_current_detect_in,
  input wire logic signed [DATA_W-1:0] vin_sample_in,
  input wire logic signed [DATA_W-1:0] vbulk_sample_in,
  input wire logic [DATA_W-1:0] bulk_min_in,
  input wire logic signed [NUM_SECT-1:0][4:0][DATA_W-1:0] coef_in,
  output logic pwm_out,
  output logic cur_trig_out,
  output logic volt_trig_out,
  output logic cur_irq_out,
  output logic volt_irq_out,
  output logic relay_close_out,
  output logic trap_out,
  output logic [CNT_W-1:0] cond_time_out,
  output logic cond_valid_out,
  output logic signed [DATA_W-1:0] vin_filt_out,
  output logic signed [DATA_W-1:0] vbulk_filt_out,
  output logic [1:0] state_out
);
  localparam int unsigned TICK_W = $clog2(TICK_CYCLES + 1);
  localparam int unsigned RLY_W = $clog2(RELAY_CYCLES + 1);

  // timers and shadowed compares
  logic [CNT_W-1:0] cnt_q, cnt_d, rep_q, rep_d, cap_q, cap_d;
  logic [CNT_W-1:0] duty_sh_q, duty_sh_d, duty_q, duty_d, samp_q, samp_d;
  logic [CNT_W-1:0] cond_q, cond_d, volt_pt;
  logic [CNT_W:0] off_len;
  logic boundary, pwm_q, pwm_d, ctrig_q, ctrig_d, vtrig_q, vtrig_d;
  logic cirq_q, cirq_d, cdone_q, cdone_d, zcd_q, zcd_d, cvld_q, cvld_d, trap_q, trap_d;
  // tick and sequencer
  logic [TICK_W-1:0] tick_q, tick_d;
  logic [RLY_W-1:0] rly_q, rly_d;
  logic tirq_q, tirq_d, relay_q, relay_d, bulk_low;
  pps_seq_t st_q, st_d;

  assign boundary = (cnt_q == PERIOD_LAST);
  assign off_len = (CNT_W + 1)'(PERIOD_CYC) - (CNT_W + 1)'(duty_q);
  assign volt_pt = duty_q + off_len[CNT_W:1];
  assign bulk_low = ($signed({1'b0, bulk_min_in}) > $signed({vbulk_sample_in[DATA_W-1],
                     vbulk_sample_in}));

  // period timers, compares, triggers, capture
  always_comb begin
    cnt_d = boundary ? '0 : cnt_q + 1'b1;
    rep_d = boundary ? '0 : rep_q + 1'b1;
    duty_sh_d = duty_load_in ? ((duty_in > PERIOD_CYC) ? PERIOD_CYC : duty_in) : duty_sh_q;
    // both compares swap only at the boundary so a period never mixes old and new
    duty_d = boundary ? duty_sh_q : duty_q;
    samp_d = boundary ? (duty_sh_q >> 1) : samp_q;
    trap_d = peak_current_limit_in || (trap_q && !trap_clear_in);
    // registered on-time, cut immediately below by the comparator itself; next state
    // is used so the switch is already off in the first cycle outside run
    pwm_d = (st_d == PPS_RUN) && !trap_d && (cnt_d < duty_d);
    ctrig_d = (cnt_q == samp_q) && (samp_q != '0);
    vtrig_d = (rep_q == volt_pt) && (duty_q < PERIOD_CYC);
    // a result landing on the boundary counts for the new period (set wins)
    cdone_d = cur_conv_done_in || (cdone_q && !boundary);
    cirq_d = cur_conv_done_in && !cdone_q;
    zcd_d = zero_current_detect_in;
    cap_d = boundary ? '0 : cap_q + 1'b1;
    cond_d = cond_q;
    cvld_d = 1'b0;
    if (zcd_q && !zero_current_detect_in) begin
      cond_d = cap_q;
      cvld_d = 1'b1;
    end
  end

  always_ff @(posedge sys_clk_in or posedge reset_in) begin
    if (reset_in) begin
      cnt_q <= '0;
      rep_q <= '0;
      cap_q <= '0;
      duty_sh_q <= DUTY_RESET;
      duty_q <= DUTY_RESET;
      samp_q <= DUTY_RESET;
      cond_q <= '0;
      pwm_q <= 1'b0;
      ctrig_q <= 1'b0;
      vtrig_q <= 1'b0;
      cdone_q <= 1'b0;
      cirq_q <= 1'b0;
      trap_q <= 1'b0;
      zcd_q <= 1'b0;
      cvld_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      rep_q <= rep_d;
      cap_q <= cap_d;
      duty_sh_q <= duty_sh_d;
      duty_q <= duty_d;
      samp_q <= samp_d;
      cond_q <= cond_d;
      pwm_q <= pwm_d;
      ctrig_q <= ctrig_d;
      vtrig_q <= vtrig_d;
      cdone_q <= cdone_d;
      cirq_q <= cirq_d;
      trap_q <= trap_d;
      zcd_q <= zcd_d;
      cvld_q <= cvld_d;
    end
  end

  // fixed_rate_tick and start-up sequencer
  always_comb begin
    tick_d = (tick_q == TICK_W'(TICK_CYCLES - 1)) ? '0 : tick_q + 1'b1;
    tirq_d = (tick_q == TICK_W'(TICK_CYCLES - 1));
    st_d = st_q;
    rly_d = rly_q;
    relay_d = relay_q;
    case (st_q)
      PPS_IDLE: begin
        relay_d = 1'b0;
        rly_d = '0;
        if (enable_in && !bulk_low) begin
          st_d = PPS_RELAY;
          relay_d = 1'b1;
        end
      end
      PPS_RELAY: begin
        rly_d = rly_q + 1'b1;
        if (tirq_q && bulk_low) begin
          st_d = PPS_IDLE;
          relay_d = 1'b0;
        end else if (rly_q == RLY_W'(RELAY_CYCLES - 1)) begin
          st_d = PPS_RUN;
        end
      end
      PPS_RUN: begin
        // bulk checked once per tick so a noisy sample cannot chatter the relay
        if (tirq_q && bulk_low) begin
          st_d = PPS_IDLE;
          relay_d = 1'b0;
        end else if (!enable_in) begin
          st_d = PPS_IDLE;
        end
      end
      default: begin
        st_d = PPS_IDLE;
        relay_d = 1'b0;
      end
    endcase
  end

  always_ff @(posedge sys_clk_in or posedge reset_in) begin
    if (reset_in) begin
      tick_q <= '0;
      tirq_q <= 1'b0;
      st_q <= PPS_IDLE;
      rly_q <= '0;
      relay_q <= 1'b0;
    end else begin
      tick_q <= tick_d;
      tirq_q <= tirq_d;
      st_q <= st_d;
      rly_q <= rly_d;
      relay_q <= relay_d;
    end
  end

  // two cascaded sections per filter, both stepped by the tick
  pps_bq_if bq[NUM_SECT] ();
  for (genvar i = 0; i < NUM_SECT; i++) begin : g_sect
    if (i % 2 == 0) begin : g_head
      assign bq[i].x = (i == 0) ? vin_sample_in : vbulk_sample_in;
      assign bq[i].x_vld = tirq_q;
    end else begin : g_tail
      assign bq[i].x = bq[i-1].y;
      assign bq[i].x_vld = bq[i-1].y_vld;
    end
    assign bq[i].coef = coef_in[i];
    pps_biquad u_bq (
      .sys_clk_in(sys_clk_in),
      .reset_in(reset_in),
      .bq(bq[i])
    );
  end

  // comparator gates the pin directly; the registered path alone would lag a cycle
  assign pwm_out = pwm_q && !peak_current_limit_in;
  assign cur_trig_out = ctrig_q;
  assign volt_trig_out = vtrig_q;
  assign cur_irq_out = cirq_q;
  assign volt_irq_out = tirq_q;
  assign relay_close_out = relay_q;
  assign trap_out = trap_q;
  assign cond_time_out = cond_q;
  assign cond_valid_out = cvld_q;
  assign vin_filt_out = bq[1].y;
  assign vbulk_filt_out = bq[3].y;
  assign state_out = st_q;

  sequence s_trip;
    peak_current_limit_in;
  endsequence
  sequence s_dark;
    !pwm_out ##1 !pwm_out;
  endsequence

  a_period_wrap: assert property (@(posedge sys_clk_in) disable iff (reset_in)
    boundary |=> cnt_q == '0 && rep_q == '0) else $error("period wrap wrong");
  a_replica_lock: assert property (@(posedge sys_clk_in) disable iff (reset_in)
    rep_q == cnt_q) else $error("replica out of step");
  a_sample_half: assert property (@(posedge sys_clk_in) disable iff (reset_in)
    samp_q == (duty_q >> 1)) else $error("sample compare not half duty");
  a_duty_boundary: assert property (@(posedge sys_clk_in) disable iff (reset_in)
    !$past(boundary) |-> $stable(duty_q)) else $error("duty changed mid period");
  a_trip_stops: assert property (@(posedge sys_clk_in) disable iff (reset_in)
    s_trip |-> !pwm_out ##1 trap_out) else $error("trip did not stop pwm");
  // a clear in the next cycle may legally let the switch back on after it
  a_trap_holds: assert property (@(posedge sys_clk_in) disable iff (reset_in)
    trap_q && !trap_clear_in ##1 !trap_clear_in |-> s_dark)
    else $error("pwm during trap");
  a_run_only: assert property (@(posedge sys_clk_in) disable iff (reset_in)
    st_q != PPS_RUN |-> !pwm_q) else $error("pwm outside run");
  a_relay_first: assert property (@(posedge sys_clk_in) disable iff (reset_in)
    pwm_out |-> relay_close_out) else $error("switching with relay open");
  a_tick_spacing: assert property (@(posedge sys_clk_in) disable iff (reset_in)
    volt_irq_out |=> !volt_irq_out [*8]) else $error("tick too close");
  a_one_irq: assert property (@(posedge sys_clk_in) disable iff (reset_in)
    cdone_q |=> !cur_irq_out) else $error("extra current irq");
  a_done_irq: assert property (@(posedge sys_clk_in) disable iff (reset_in)
    cur_conv_done_in && !cdone_q |=> cur_irq_out) else $error("current irq missing");
  a_bulk_restart: assert property (@(posedge sys_clk_in) disable iff (reset_in)
    st_q == PPS_RUN && tirq_q && bulk_low |=> !relay_close_out && st_q == PPS_IDLE)
    else $error("bulk low not handled");
  a_cap_clear: assert property (@(posedge sys_clk_in) disable iff (reset_in)
    boundary |=> cap_q == '0) else $error("capture not cleared");
  a_cap_grab: assert property (@(posedge sys_clk_in) disable iff (reset_in)
    zcd_q && !zero_current_detect_in |=> cond_valid_out && cond_time_out == $past(cap_q))
    else $error("conduction time not captured");
endmodule : pps_pwm_sampling_sequencer

// [bench/pps_stage_model.sv]
`timescale 1ns/10ps
// stand-in for the current converter and the zero-current comparator
module pps_stage_model
  import pps_pkg::*;
(
  input wire logic sys_clk_in,
  input wire logic reset_in,
  input wire logic pwm_in,
  input wire logic cur_trig_in,
  input wire logic [CNT_W-1:0] zero_end_in,
  output logic conv_done_out,
  output logic zcd_out
);
  logic [7:0] trig_q;
  logic pwm_q;
  logic [15:0] n_q;
  // result 5 cycles after launch, then a stray late one the block must ignore
  assign conv_done_out = trig_q[4] | trig_q[7];
  // n follows the period count; comparator falls at the programmed count
  always_ff @(posedge sys_clk_in or posedge reset_in) begin
    if (reset_in) begin
      trig_q <= 8'h00;
      pwm_q <= 1'b0;
      n_q <= 16'h0000;
      zcd_out <= 1'b0;
    end else begin
      trig_q <= {trig_q[6:0], cur_trig_in};
      pwm_q <= pwm_in;
      n_q <= (pwm_in && !pwm_q) ? 16'h0001 : n_q + 16'h0001;
      zcd_out <= (n_q < 16'(zero_end_in) - 16'h0001);
    end
  end
endmodule : pps_stage_model

// [bench/tb_pfc_pwm_sampling_sequencer.sv]
`timescale 1ns/10ps
module tb_pfc_pwm_sampling_sequencer;
  import pps_pkg::*;
  localparam int TICKS = 20;
  localparam int PER = 1538;
  localparam int ZEND = 300;
  logic sys_clk_in = 1'b0;
  logic reset_in = 1'b1;
  logic enable_in = 1'b0;
  logic [CNT_W-1:0] duty_in = 11'h000;
  logic duty_load_in = 1'b0;
  logic cur_conv_done_in;
  logic peak_current_limit_in = 1'b0;
  logic trap_clear_in = 1'b0;
  logic zero_current_detect_in;
  logic signed [DATA_W-1:0] vin_sample_in = 16'h1234;
  logic signed [DATA_W-1:0] vbulk_sample_in = 16'h6000;
  logic [DATA_W-1:0] bulk_min_in = 16'h5000;
  logic signed [NUM_SECT-1:0][4:0][DATA_W-1:0] coef_in;
  logic pwm_out, cur_trig_out, volt_trig_out, cur_irq_out, volt_irq_out;
  logic relay_close_out, trap_out, cond_valid_out;
  logic [CNT_W-1:0] cond_time_out;
  logic signed [DATA_W-1:0] vin_filt_out, vbulk_filt_out;
  logic [1:0] state_out;
  int error_cnt = 0;
  int n_checks = 0;

  pps_pwm_sampling_sequencer #(.TICK_CYCLES(TICKS), .RELAY_CYCLES(8)) DUT (
    .sys_clk_in, .reset_in, .enable_in, .duty_in, .duty_load_in, .cur_conv_done_in,
    .peak_current_limit_in, .trap_clear_in, .zero_current_detect_in, .vin_sample_in,
    .vbulk_sample_in, .bulk_min_in, .coef_in, .pwm_out, .cur_trig_out, .volt_trig_out,
    .cur_irq_out, .volt_irq_out, .relay_close_out, .trap_out, .cond_time_out,
    .cond_valid_out, .vin_filt_out, .vbulk_filt_out, .state_out);

  pps_stage_model PS (.sys_clk_in, .reset_in, .pwm_in(pwm_out), .cur_trig_in(cur_trig_out),
    .zero_end_in(CNT_W'(ZEND)), .conv_done_out(cur_conv_done_in),
    .zcd_out(zero_current_detect_in));

  always #5 sys_clk_in = ~sys_clk_in;

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic complete_run();
    if (error_cnt == 0 && n_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : complete_run

  // bounded wait for a sequencer state, counting pwm on-cycles meanwhile
  task automatic wait_state(input logic [1:0] s, input int lim, output int on);
    int k = 0;
    on = 0;
    while (state_out !== s && k < lim) begin
      @(posedge sys_clk_in);
      // only cycles still short of the awaited state count as early switching
      on += int'(pwm_out === 1'b1 && state_out !== s);
      k++;
    end
    check(k < lim, 1);
  endtask : wait_state

  // one switching period seen from its first on-cycle; nxt loads a new duty mid-way
  task automatic run_period(input int duty, input int nxt);
    int cur_i = -1, volt_i = -1, irq_i = -1, irq_n = 0, on_n = 1, k = 0;
    logic [CNT_W-1:0] cap = 11'h7FF;
    while (!(pwm_out === 1'b1 && k > 0) && k < 4000) begin
      @(posedge sys_clk_in);
      k = (pwm_out === 1'b1 && k == 0) ? 0 : k + 1;
    end
    check(k < 4000, 1);
    for (int i = 1; i < PER; i++) begin
      @(posedge sys_clk_in);
      duty_in <= CNT_W'(nxt);
      duty_load_in <= (i == 100 && nxt > 0);
      on_n += int'(pwm_out === 1'b1);
      if (cur_trig_out === 1'b1) cur_i = i;
      if (volt_trig_out === 1'b1) volt_i = i;
      if (cur_irq_out === 1'b1) begin
        irq_i = i;
        irq_n++;
      end
      if (cond_valid_out === 1'b1) cap = cond_time_out;
    end
    @(posedge sys_clk_in);
    check(pwm_out, 1);
    check(on_n, duty);
    check(cur_i, duty / 2 + 1);
    check(volt_i, duty + (PER - duty) / 2 + 1);
    check(irq_n, 1);
    check(irq_i, cur_i + 6);
    check(cap, ZEND);
  endtask : run_period

  // relay closes, switching held off until the settle time is over
  task automatic t_startup();
    int on;
    enable_in <= 1'b1;
    duty_in <= 11'h190;
    duty_load_in <= 1'b1;
    wait_state(PPS_RELAY, 40, on);
    check(relay_close_out, 1);
    wait_state(PPS_RUN, 14, on);
    check(on, 0);
  endtask : t_startup

  // tick spacing and the filter cascades; bulk path has gain -1 to exercise signed products
  task automatic t_tick();
    int k = 0;
    while (volt_irq_out !== 1'b1 && k < 60) begin
      @(posedge sys_clk_in);
      k++;
    end
    k = 0;
    do begin
      @(posedge sys_clk_in);
      k++;
    end while (volt_irq_out !== 1'b1 && k < 60);
    check(k, TICKS);
    repeat (4) @(posedge sys_clk_in);
    check(vin_filt_out, 32'(16'h1234));
    check(vbulk_filt_out, 32'hFFFFA000);
  endtask : t_tick

  // over-current trip kills the switch at once and stays latched
  task automatic t_trap();
    int on = 0;
    repeat (20) @(posedge sys_clk_in);
    peak_current_limit_in <= 1'b1;
    @(posedge sys_clk_in);
    #1 check(pwm_out, 0);
    @(posedge sys_clk_in);
    peak_current_limit_in <= 1'b0;
    #1 check(trap_out, 1);
    repeat (1600) begin
      @(posedge sys_clk_in);
      on += int'(pwm_out === 1'b1);
    end
    check(on, 0);
    check(trap_out, 1);
    trap_clear_in <= 1'b1;
    @(posedge sys_clk_in);
    trap_clear_in <= 1'b0;
  endtask : t_trap

  // low bulk drops the relay and the switching, then start-up repeats
  task automatic t_brownout();
    int on;
    vbulk_sample_in <= 16'h1000;
    wait_state(PPS_IDLE, 3 * TICKS, on);
    @(posedge sys_clk_in);
    check(relay_close_out, 0);
    check(pwm_out, 0);
    vbulk_sample_in <= 16'h6000;
    wait_state(PPS_RELAY, 3 * TICKS, on);
    check(relay_close_out, 1);
    wait_state(PPS_RUN, 14, on);
    check(on, 0);
  endtask : t_brownout

  initial begin
    coef_in = '0;
    for (int s = 0; s < NUM_SECT; s++) coef_in[s][0] = 16'h4000;
    coef_in[3][0] = 16'hC000;
    repeat (20) @(posedge sys_clk_in);
    reset_in <= 1'b0;
    t_startup();
    run_period(400, 1000);
    run_period(1000, 0);
    t_tick();
    t_trap();
    run_period(1000, 0);
    t_brownout();
    run_period(1000, 0);
    complete_run();
  end

  // hang guard, well past the roughly 14k cycles the sequence needs
  initial begin
    #900_000;
    error_cnt++;
    complete_run();
  end
endmodule : tb_pfc_pwm_sampling_sequencer
